// ===== src/addr_check_defs.svh
// constants for the address bypass and size-check front end
// assumes: included by iommu_addr_pkg.sv and the design module
//
// Notes on behaviour
// - short scheme takes transient hint from request, as changed by stream entry
// - walk_disable_zero is honoured for hyp and monitor banks, not ignored
// - secure hyp bank applies its walk_nonsecure_cfg to table walk accesses
// - stage 2 bypass context does attribute-only second stage, walks included
// - nonsecure non-hyp banks carry a vm identifier even with stage 2 bypass
// - nonsecure ipa space scheme uses a single stage, stage 2 only
// - instr_attr_override can turn instruction fetches into data accesses
// - secure instruction fetch check follows the override
// - user cache maintenance control applies even with translation disabled
// - invalidate-all command write only sets status bit 8; no entries held here
// - ipa beyond ipa_width_field raises address size fault
// - pa beyond output_addr_width_field raises address size fault
// - va up to 32 bits short, 49 bits long; bit 48 picks table base
// - granules 4KB, 16KB, 64KB supported, larger blocks too
// - ipa and pa widths at most 48 bits
// - report upstream, ipa and output address widths
// - without stage 1, upstream and ipa widths reported equal
// - without stage 2, ipa and output widths reported equal
// - effective ipa width is ipa width, or min(ipa, output) for bypass
// - pa range limit from second control for stage 1, primary for stage 2
// - bypassed address truncated to output address width
// - bypass on port disable, bypass entry, or bad match with fault cfg 0
// - sign extend only stage 1 long format enabled non-hyp non-monitor
// - nonzero bits above sign_ext_position raise level 0 translation fault
`ifndef ADDR_CHECK_DEFS_SVH
`define ADDR_CHECK_DEFS_SVH

// ============================================================
// register offsets
`define OFS_CTRL        12'h000
`define OFS_CAP         12'h004
`define OFS_STREAM      12'h008
`define OFS_BANK        12'h00C
`define OFS_TCTRL       12'h010
`define OFS_STATUS      12'h014
`define OFS_FAULT_LO    12'h018
`define OFS_FAULT_HI    12'h01C
`define OFS_TLB_CMD     12'h020

// ============================================================
// widths and reset values
`define UBS_BITS        6'd49
`define IAS_BITS        6'd48
`define OAS_BITS        6'd48
`define MAX_ADDR_BITS   49
`define STAGE1_SUP      1'b1
`define STAGE2_SUP      1'b1
`define GRANULE_SET     3'h7
`define CTRL_RESET      32'h00000001
`define ZERO_WORD       32'h00000000

// ============================================================
// field positions
`define CTRL_PORT_DIS   0
`define CTRL_USF_CFG    1
`define STR_TYPE_LO     0
`define STR_INST_LO     2
`define STR_TRANS_OVR   4
`define STR_TRANS_VAL   5
`define BANK_S2_BYPASS  0
`define BANK_HYP        1
`define BANK_MON        2
`define BANK_SECURE     3
`define BANK_LONG_FMT   4
`define BANK_XLAT_EN    5
`define BANK_SHORT_FMT  6
`define BANK_VMID_LO    8
`define BANK_UCI        16
`define BANK_S2_ONLY    17
`define TC_WALK_DIS0    0
`define TC_WALK_NS      1
`define TC_PA_S2_LO     2
`define TC_PA2_S1_LO    8
`define TC_SEP_LO       16
`define TC_SEC_IFETCH   24

`endif

// ===== src/iommu_addr_pkg.sv
// types for the address bypass and size-check front end
// assumes: addr_check_defs.svh is on the include path
`include "addr_check_defs.svh"

package iommu_addr_pkg;

    typedef enum logic [1:0] {
        STR_TRANSLATE = 2'b00,
        STR_BYPASS    = 2'b01,
        STR_FAULT     = 2'b10
    } stream_type_t;

    typedef enum logic [1:0] {
        INST_AS_SIGNALLED = 2'b00,
        INST_FORCE_DATA   = 2'b10,
        INST_FORCE_INSTR  = 2'b11
    } instr_cfg_t;

    typedef enum logic [1:0] {
        RESULT_PASS     = 2'b00,
        RESULT_BYPASS   = 2'b01,
        RESULT_FAULT    = 2'b11
    } result_t;

    typedef struct packed {
        logic [48:0] addr;
        logic        instr;
        logic        secure;
        logic        user;
        logic        transient;
        logic        walk;
        logic        cache_maint;
        logic [1:0]  match_count;
        logic        short_fmt_va;
    } req_t;

    typedef struct packed {
        logic [47:0] addr;
        logic        instr;
        logic        secure;
        logic        transient;
        logic        bypass;
        logic        translate;
        logic        attr_only_s2;
        logic        walk_nonsecure;
        logic        ttb_sel;
        logic [7:0]  vmid;
    } fwd_t;

    typedef struct packed {
        logic size_ipa;
        logic size_pa;
        logic xlat_l0;
        logic sec_ifetch;
        logic cache_maint;
        logic walk_dis;
        logic usf;
    } fault_t;

endpackage

// ===== src/iommu_address_bypass_check.sv
// address bypass and size-check front end of an io memory management unit
// assumes: ahb-lite single word transfers, one request per cycle upstream
`timescale 1ns/1ps
`default_nettype none
`include "addr_check_defs.svh"

module iommu_address_bypass_check
    import iommu_addr_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // upstream request
    input  wire logic        req_valid,
    input  wire req_t        req,
    // downstream result
    output logic             fwd_valid,
    output fwd_t             fwd,
    output result_t          result,
    output fault_t           fault
);

    // ============================================================
    // decode helpers
    function automatic logic [5:0] pa_code_bits(input logic [2:0] code);
        unique case (code)
            3'h0: pa_code_bits = 6'd32;
            3'h1: pa_code_bits = 6'd36;
            3'h2: pa_code_bits = 6'd40;
            3'h3: pa_code_bits = 6'd42;
            3'h4: pa_code_bits = 6'd44;
            default: pa_code_bits = 6'd48;
        endcase
    endfunction

    function automatic logic fits(input logic [48:0] a, input logic [5:0] w);
        logic [48:0] m;
        m = ~((49'h1 << w) - 49'h1);
        fits = (a & m) == 49'h0;
    endfunction

    function automatic logic [5:0] min6(input logic [5:0] a, input logic [5:0] b);
        min6 = (a < b) ? a : b;
    endfunction

    // ============================================================
    // registers
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] stream_r, stream_nxt;
    logic [31:0] bank_r, bank_nxt;
    logic [31:0] tctrl_r, tctrl_nxt;
    logic [31:0] status_r, status_nxt;
    logic [48:0] faddr_r, faddr_nxt;
    logic        wr_pend_r, wr_pend_nxt;
    logic [11:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;

    logic        ahb_take;
    logic [31:0] cap_word;

    assign ahb_take  = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    // capability word: ubs[5:0], ias[13:8], oas[21:16], s1[24], s2[25], granules[30:28]
    assign cap_word = {1'b0, `GRANULE_SET, 2'b00, `STAGE2_SUP, `STAGE1_SUP,
                       2'b00, `OAS_BITS, 2'b00, `IAS_BITS, 2'b00, `UBS_BITS};

    // ============================================================
    // datapath
    logic        bypass, is_data, s1_ctx, sext_on, sext_bad;
    logic [5:0]  eff_ipa, pa_lim, sign_ext_position;
    logic [48:0] a_in;
    fault_t      f;
    fwd_t        o;
    stream_type_t st;
    instr_cfg_t   icfg;

    always_comb begin
        st   = stream_type_t'(stream_r[`STR_TYPE_LO +: 2]);
        icfg = instr_cfg_t'(stream_r[`STR_INST_LO +: 2]);
        a_in = req.short_fmt_va ? {17'h0, req.addr[31:0]} : req.addr;
        bypass = ctrl_r[`CTRL_PORT_DIS] || (st == STR_BYPASS) ||
                 ((req.match_count != 2'd1) && !ctrl_r[`CTRL_USF_CFG]);
        unique case (icfg)
            INST_FORCE_DATA:  is_data = 1'b1;
            INST_FORCE_INSTR: is_data = 1'b0;
            default:          is_data = !req.instr;
        endcase
        s1_ctx  = !bank_r[`BANK_S2_ONLY];
        eff_ipa = bank_r[`BANK_S2_BYPASS] ? min6(`IAS_BITS, `OAS_BITS) : `IAS_BITS;
        pa_lim  = min6(`OAS_BITS, s1_ctx ? pa_code_bits(tctrl_r[`TC_PA2_S1_LO +: 3])
                                         : pa_code_bits(tctrl_r[`TC_PA_S2_LO +: 3]));
        sign_ext_position     = tctrl_r[`TC_SEP_LO +: 6];
        sext_on = s1_ctx && bank_r[`BANK_LONG_FMT] && bank_r[`BANK_XLAT_EN] &&
                  !bank_r[`BANK_HYP] && !bank_r[`BANK_MON];
        sext_bad = sext_on && (sign_ext_position < 6'd48) &&
                   !fits(a_in, sign_ext_position + 6'd1);
        f = '0;
        o = '0;
        if (!bypass) begin
            f.usf        = (st == STR_FAULT) || (req.match_count != 2'd1);
            f.xlat_l0    = sext_bad;
            f.size_ipa   = !s1_ctx && !fits(a_in, eff_ipa);
            f.size_pa    = !fits(a_in, pa_lim);
            f.sec_ifetch = !is_data && req.secure && tctrl_r[`TC_SEC_IFETCH];
            f.cache_maint = req.cache_maint && req.user && !bank_r[`BANK_UCI];
            f.walk_dis   = req.walk && tctrl_r[`TC_WALK_DIS0];
        end
        o.addr = bypass ? a_in[47:0] & ~(48'hFFFFFFFFFFFF << `OAS_BITS)
                        : ((sext_on && sign_ext_position < 6'd48) ? {48{a_in[sign_ext_position]}} & ~((48'h1 << sign_ext_position) - 48'h1)
                                     | a_in[47:0] & ((48'h1 << sign_ext_position) - 48'h1)
                                   : a_in[47:0]);
        o.instr  = !is_data;
        o.secure = req.secure;
        o.transient = (bank_r[`BANK_SHORT_FMT] && stream_r[`STR_TRANS_OVR]) ?
                      stream_r[`STR_TRANS_VAL] : req.transient;
        o.bypass    = bypass;
        o.translate = !bypass && bank_r[`BANK_XLAT_EN];
        o.attr_only_s2 = !bypass && bank_r[`BANK_S2_BYPASS];
        o.walk_nonsecure = req.walk && bank_r[`BANK_HYP] && bank_r[`BANK_SECURE] &&
                           tctrl_r[`TC_WALK_NS];
        o.ttb_sel = !req.short_fmt_va && a_in[48];
        o.vmid = (!bank_r[`BANK_SECURE] && !bank_r[`BANK_HYP]) ?
                 bank_r[`BANK_VMID_LO +: 8] : 8'h00;
    end

    // ============================================================
    // register write/read and fault capture
    always_comb begin
        ctrl_nxt    = ctrl_r;
        stream_nxt  = stream_r;
        bank_nxt    = bank_r;
        tctrl_nxt   = tctrl_r;
        status_nxt  = status_r;
        faddr_nxt   = faddr_r;
        wr_pend_nxt = ahb_take && hwrite;
        wr_addr_nxt = haddr;
        hrdata_nxt  = hrdata_r;
        if (wr_pend_r) begin
            unique case (wr_addr_r)
                `OFS_CTRL:    ctrl_nxt   = hwdata;
                `OFS_STREAM:  stream_nxt = hwdata;
                `OFS_BANK:    bank_nxt   = hwdata;
                `OFS_TCTRL:   tctrl_nxt  = hwdata;
                `OFS_STATUS:  status_nxt = status_r & ~hwdata;
                `OFS_TLB_CMD: if (hwdata[0]) status_nxt[8] = 1'b1;
                default: ;
            endcase
        end
        // faults set status sticky bits; set beats clear
        if (req_valid && (|f)) begin
            status_nxt[6:0] = status_nxt[6:0] | f;
            faddr_nxt = a_in;
        end
        if (ahb_take && !hwrite) begin
            unique case (haddr)
                `OFS_CTRL:     hrdata_nxt = ctrl_r;
                `OFS_CAP:      hrdata_nxt = cap_word;
                `OFS_STREAM:   hrdata_nxt = stream_r;
                `OFS_BANK:     hrdata_nxt = bank_r;
                `OFS_TCTRL:    hrdata_nxt = tctrl_r;
                `OFS_STATUS:   hrdata_nxt = status_r;
                `OFS_FAULT_LO: hrdata_nxt = faddr_r[31:0];
                `OFS_FAULT_HI: hrdata_nxt = {15'h0, faddr_r[48:32]};
                default:       hrdata_nxt = `ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r    <= `CTRL_RESET;
            stream_r  <= `ZERO_WORD;
            bank_r    <= `ZERO_WORD;
            tctrl_r   <= `ZERO_WORD;
            status_r  <= `ZERO_WORD;
            faddr_r   <= 49'h0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            hrdata_r  <= `ZERO_WORD;
        end else begin
            ctrl_r    <= ctrl_nxt;
            stream_r  <= stream_nxt;
            bank_r    <= bank_nxt;
            tctrl_r   <= tctrl_nxt;
            status_r  <= status_nxt;
            faddr_r   <= faddr_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            hrdata_r  <= hrdata_nxt;
        end
    end

    // ============================================================
    // registered downstream result, one cycle after request
    logic    fv_r, fv_nxt;
    fwd_t    fwd_r, fwd_nxt;
    result_t res_r, res_nxt;
    fault_t  flt_r, flt_nxt;

    always_comb begin
        fv_nxt  = req_valid;
        fwd_nxt = req_valid ? o : '0;
        flt_nxt = req_valid ? f : '0;
        res_nxt = !req_valid ? RESULT_PASS :
                  (|f) ? RESULT_FAULT : (bypass ? RESULT_BYPASS : RESULT_PASS);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fv_r  <= 1'b0;
            fwd_r <= '0;
            res_r <= RESULT_PASS;
            flt_r <= '0;
        end else begin
            fv_r  <= fv_nxt;
            fwd_r <= fwd_nxt;
            res_r <= res_nxt;
            flt_r <= flt_nxt;
        end
    end

    assign fwd_valid = fv_r;
    assign fwd       = fwd_r;
    assign result    = res_r;
    assign fault     = flt_r;

endmodule
`default_nettype wire

// ===== test/bypass_check_asserts.sv
// checker for the address bypass and size-check front end
// assumes: bound to the top module, single clock hclk
`timescale 1ns/1ps
`default_nettype none
`include "addr_check_defs.svh"
module bypass_check_asserts
    import iommu_addr_pkg::*;
(
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // register bus
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    // request and result
    input wire logic        req_valid,
    input wire req_t        req,
    input wire logic        fwd_valid,
    input wire fwd_t        fwd,
    input wire result_t     result,
    input wire fault_t      fault
);
    // ============================================================
    // shadow of control and stream entry
    logic        wr_r;
    logic [11:0] wa_r;
    logic [1:0]  ctl_r;
    logic [5:0]  str_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_r  <= 1'b0;
            wa_r  <= 12'h000;
            ctl_r <= 2'h1;
            str_r <= 6'h00;
        end else begin
            wr_r <= hsel && hready && htrans[1] && hwrite;
            wa_r <= haddr;
            if (wr_r && wa_r == `OFS_CTRL)
                ctl_r <= hwdata[1:0];
            if (wr_r && wa_r == `OFS_STREAM)
                str_r <= hwdata[5:0];
        end
    end

    // ============================================================
    // properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_bypassed;
        fwd_valid && result == RESULT_BYPASS && fwd.bypass;
    endsequence
    sequence s_no_match;
        req_valid && str_r[1:0] == 2'h0 && req.match_count != 2'h1;
    endsequence

    a_fwd_follows: assert property (req_valid |=> fwd_valid)
        else $error("no result after request");
    a_fwd_quiet: assert property (!req_valid |=> !fwd_valid)
        else $error("result without request");
    a_port_bypass: assert property (req_valid && ctl_r[0] |=> s_bypassed)
        else $error("port disable did not bypass");
    a_bypass_trunc: assert property (req_valid && ctl_r[0] |=>
        fwd.addr == $past(req.addr[47:0]))
        else $error("bypassed address not truncated");
    a_bypass_attrs: assert property (req_valid && ctl_r[0] && str_r[4:2] == 3'h0 |=>
        fwd.secure == $past(req.secure) && fwd.instr == $past(req.instr)
        && fwd.transient == $past(req.transient))
        else $error("bypassed attributes changed");
    a_nomatch_bypass: assert property (s_no_match ##0 ctl_r == 2'h0 |=> s_bypassed)
        else $error("unmatched stream not bypassed");
    a_usf_fault: assert property (s_no_match ##0 ctl_r == 2'h2 |=>
        result == RESULT_FAULT && fault.usf)
        else $error("unmatched stream fault missing");
    a_stream_bypass: assert property (req_valid && str_r[1:0] == 2'h1 |=> s_bypassed)
        else $error("bypass entry not bypassed");
    a_force_data: assert property (req_valid && str_r[3:2] == 2'h2 |=>
        !fwd.instr && !fault.sec_ifetch)
        else $error("instruction override ignored");
endmodule

bind iommu_address_bypass_check bypass_check_asserts chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .req_valid(req_valid), .req(req),
    .fwd_valid(fwd_valid), .fwd(fwd), .result(result), .fault(fault));
`default_nettype wire

// ===== test/test_iommu_address_bypass_check.sv
// self-checking bench for the address bypass and size-check front end
// assumes: bench is the ahb-lite master, partner model issues requests
`timescale 1ns/1ps
`default_nettype none
`include "addr_check_defs.svh"
module test_iommu_address_bypass_check
    import iommu_addr_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        send = 1'b0;
    req_t        sreq = '0;
    logic        req_valid;
    req_t        req;
    logic        fwd_valid;
    fwd_t        fwd;
    result_t     result;
    fault_t      fault;
    int          failures = 0;
    int          checked = 0;
    logic [31:0] q;

    typedef struct {
        logic [1:0]  ctl;
        logic [5:0]  str;
        logic [17:0] bnk;
        logic [24:0] tc;
        logic [48:0] a;
        logic [1:0]  mc;
        logic [2:0]  ist;
        result_t     res;
        logic [1:0]  ot;
        logic [6:0]  f;
    } row_t;

    // ============================================================
    // ordinary cases: config, request {instr,secure,transient}, result
    row_t rows [10] = '{
        '{2'h1, 6'h00, 18'h0, 25'h0, 49'h1_2345_6789_ABCD, 2'h1, 3'h3, RESULT_BYPASS, 2'h1, 7'h00},
        '{2'h0, 6'h01, 18'h0, 25'h0, 49'h0_0000_0000_1000, 2'h1, 3'h4, RESULT_BYPASS, 2'h2, 7'h00},
        '{2'h0, 6'h00, 18'h0, 25'h0, 49'h0_0000_0000_2000, 2'h0, 3'h0, RESULT_BYPASS, 2'h0, 7'h00},
        '{2'h0, 6'h00, 18'h0, 25'h0, 49'h0_0000_0000_3000, 2'h2, 3'h0, RESULT_BYPASS, 2'h0, 7'h00},
        '{2'h2, 6'h00, 18'h0, 25'h0, 49'h0_0000_0000_1000, 2'h0, 3'h0, RESULT_FAULT, 2'h0, 7'h01},
        '{2'h0, 6'h00, 18'h0, 25'h0, 49'h0_0000_0000_1000, 2'h1, 3'h0, RESULT_PASS, 2'h0, 7'h00},
        '{2'h0, 6'h00, 18'h0, 25'h1000000, 49'h0_0000_0000_1000, 2'h1, 3'h6, RESULT_FAULT, 2'h0, 7'h08},
        '{2'h0, 6'h08, 18'h0, 25'h1000000, 49'h0_0000_0000_1000, 2'h1, 3'h6, RESULT_PASS, 2'h0, 7'h00},
        '{2'h0, 6'h30, 18'h40, 25'h0, 49'h0_0000_0000_1000, 2'h1, 3'h0, RESULT_PASS, 2'h1, 7'h00},
        '{2'h0, 6'h00, 18'h20000, 25'h0, 49'h1_0000_0000_1000, 2'h1, 3'h0, RESULT_FAULT, 2'h0, 7'h60}
    };

    always #4 hclk = ~hclk;

    upstream_master_model up_u (.hclk(hclk), .hresetn(hresetn), .send(send), .send_req(sreq),
        .req_valid(req_valid), .req(req));
    iommu_address_bypass_check dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .req_valid(req_valid), .req(req), .fwd_valid(fwd_valid), .fwd(fwd),
        .result(result), .fault(fault));

    // ============================================================
    // shared tasks
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic wait_edge(input logic which);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while ((which ? fwd_valid : hreadyout) !== 1'b1 && n < 20);
        if ((which ? fwd_valid : hreadyout) !== 1'b1) begin
            failures++;
            summarize();
        end
    endtask

    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_edge(1'b0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_edge(1'b0);
        q = hrdata;
    endtask

    task automatic setup(input logic [31:0] c, input logic [31:0] s, input logic [31:0] b,
                         input logic [31:0] t);
        bus(`OFS_CTRL, 1'b1, c);
        bus(`OFS_STREAM, 1'b1, s);
        bus(`OFS_BANK, 1'b1, b);
        bus(`OFS_TCTRL, 1'b1, t);
    endtask

    task automatic fire(input req_t r);
        send <= 1'b1;
        sreq <= r;
        @(posedge hclk);
        send <= 1'b0;
        wait_edge(1'b1);
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(`OFS_CTRL, 1'b0, 32'h0);
        chk("ctrl_reset", {1'b0, 10'h0, 32'h1}, {hresp, fwd_valid, result, fault, q});
    endtask

    // ============================================================
    // main sequence
    initial begin
        do_reset();
        foreach (rows[i]) begin
            setup({30'h0, rows[i].ctl}, {26'h0, rows[i].str}, {14'h0, rows[i].bnk},
                  {7'h0, rows[i].tc});
            fire({rows[i].a, rows[i].ist[2:1], 1'b0, rows[i].ist[0], 2'h0, rows[i].mc, 1'b0});
            chk("result", rows[i].res, result);
            chk("fault", rows[i].f, fault);
            if (rows[i].res != RESULT_FAULT)
                chk("instr_transient", rows[i].ot, {fwd.instr, fwd.transient});
            if (rows[i].res == RESULT_BYPASS)
                chk("fwd_addr", rows[i].a[47:0], fwd.addr);
        end
        // context attributes, sign extension, walk and maintenance faults
        setup(32'h0, 32'h0, 32'h0000_2A31, 32'h0028_0500);
        fire({49'h0_0100_0000_1000, 9'h002});
        chk("fwd_ctx", {3'b110, 8'h2A},
            {fwd.translate, fwd.attr_only_s2, fwd.ttb_sel, fwd.vmid});
        chk("sext_addr", 48'hFF00_0000_1000, fwd.addr);
        chk("fault", 7'h00, fault);
        setup(32'h0, 32'h0, 32'h0000_2A31, 32'h0020_0500);
        fire({49'h0_0100_0000_1000, 9'h002});
        chk("sext_fault", {2'h3, 7'h10}, {result, fault});
        setup(32'h0, 32'h0, 32'h0000_2A2A, 32'h0000_0502);
        fire({49'h1_0000_0000_1000, 9'h012});
        chk("fwd_walk", {2'b11, 8'h00}, {fwd.walk_nonsecure, fwd.ttb_sel, fwd.vmid});
        chk("fault", 7'h20, fault);
        setup(32'h0, 32'h0, 32'h0, 32'h1);
        fire({49'h0_0000_0000_1000, 9'h05A});
        chk("fault", {1'b0, 7'h06}, {fwd.translate, fault});
        bus(`OFS_CAP, 1'b0, 32'h0);
        chk("capability", 32'h7330_3031, q);
        bus(`OFS_CAP, 1'b1, 32'hFFFF_FFFF);
        bus(`OFS_CAP, 1'b0, 32'h0);
        chk("capability_ro", 32'h7330_3031, q);
        bus(12'h030, 1'b0, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(`OFS_TLB_CMD, 1'b1, 32'h1);
        bus(`OFS_STATUS, 1'b0, 32'h0);
        chk("tlb_done", 1'b1, q[8]);
        bus(`OFS_STATUS, 1'b1, 32'h100);
        bus(`OFS_STATUS, 1'b0, 32'h0);
        chk("tlb_cleared", 1'b0, q[8]);
        // back-to-back bypassed requests
        bus(`OFS_CTRL, 1'b1, 32'h1);
        send <= 1'b1;
        sreq <= {49'h0_0000_0000_A000, 9'h0};
        @(posedge hclk);
        sreq <= {49'h1_0000_0000_B000, 9'h0};
        @(posedge hclk);
        send <= 1'b0;
        @(posedge hclk);
        chk("b2b_first", {1'b1, 48'h0000_0000_A000}, {fwd_valid, fwd.addr});
        @(posedge hclk);
        chk("b2b_second", {1'b1, 48'h0000_0000_B000}, {fwd_valid, fwd.addr});
        do_reset();
        summarize();
    end
endmodule
`default_nettype wire

// ===== test/upstream_master_model.sv
// upstream bus-master model feeding requests into the front end
// assumes: bench pulses send once per request, single clock hclk
`timescale 1ns/1ps
`default_nettype none
module upstream_master_model
    import iommu_addr_pkg::*;
(
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // bench command
    input  wire logic send,
    input  wire req_t send_req,
    // request toward the front end
    output logic      req_valid,
    output req_t      req
);
    // ============================================================
    // request launch
    // released fields show the inverse of the last value, never a stale copy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_valid <= 1'b0;
            req       <= '0;
        end else begin
            req_valid <= send;
            req       <= send ? send_req : ~req;
        end
    end
endmodule
`default_nettype wire
